// ==== core/tdfa_target.sv ====
// target end of the two-wire debug port: selectable data registers, unlock and flash path
// assumes the host makes a free-running link clock and frames bits as in tdfa_host
`timescale 1ns/100ps
`include "tdfa_map.svh"
`default_nettype none

module tdfa_target
  import tdfa_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] REV_ID = 8'h01 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  tdfa_if.target link,
  output logic core_halted,
  output logic prog_enabled,
  output logic user_pin_in,
  output logic [7:0] flash_byte,
  output logic flash_byte_is_cmd,
  output tdfa_cmd_e flash_cmd,
  output logic flash_byte_stb,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_rdata_stb,
  input wire logic flash_done
);

  typedef enum logic [2:0] {st_idle, st_ins, st_wdat, st_turn, st_rdat} tdfa_tgt_state_e;
  typedef enum logic [1:0] {lk_locked, lk_first, lk_open} tdfa_lock_e;

  function automatic tdfa_cmd_e cmd_of(input logic [7:0] b);
    unique case (b)
      `TDFA_CMD_BLOCK_READ: cmd_of = tdfa_cmd_block_read;
      `TDFA_CMD_BLOCK_WRITE: cmd_of = tdfa_cmd_block_write;
      `TDFA_CMD_PAGE_ERASE: cmd_of = tdfa_cmd_page_erase;
      `TDFA_CMD_DEVICE_ERASE: cmd_of = tdfa_cmd_device_erase;
      default: cmd_of = tdfa_cmd_none;
    endcase
  endfunction

  // link domain
  tdfa_tgt_state_e state;
  tdfa_lock_e lock;
  logic lrst_m, lrst;
  logic [2:0] cnt;
  logic [1:0] ins;
  logic [1:0] next_ins;
  logic [7:0] shift;
  logic [7:0] wbyte;
  logic wdone;
  logic [7:0] sel;
  logic [7:0] ctl;
  logic [7:0] program_data_port;
  logic [7:0] rd_val;
  logic halt_l;
  logic cmd_phase;
  logic [7:0] byte_hold;
  logic cmd_hold;
  logic byte_tgl;
  logic [2:0] rd_sync;
  logic [2:0] done_sync;

  // system domain
  logic halt_m, open_m, pin_m, pin_s;
  logic [2:0] byte_sync;
  logic [7:0] rdata_hold;
  logic rd_tgl;
  logic done_tgl;

  assign next_ins = {ins[0], link.dat};
  assign wbyte = {shift[6:0], link.dat};
  assign wdone = (state == st_wdat) && (cnt == 3'h7);

  always_comb begin
    if (ins == `TDFA_INS_ADDR_RD) begin
      rd_val = sel;
    end else begin
      unique case (sel)
        `TDFA_ADDR_PART: rd_val = PART_ID;
        `TDFA_ADDR_REV: rd_val = REV_ID;
        `TDFA_ADDR_CTL: rd_val = ctl;
        `TDFA_ADDR_DATA: rd_val = program_data_port;
        default: rd_val = 8'h00;
      endcase
    end
  end

  // system reset is the only way out of a session, so it is carried into the link domain
  always_ff @(posedge link.link_clk) begin
    lrst_m <= rst;
    lrst <= lrst_m;
  end

  always_ff @(posedge link.link_clk) begin
    if (lrst) begin
      state <= st_idle;
      cnt <= 3'h0;
      ins <= 2'h0;
      shift <= 8'h00;
    end else begin
      unique case (state)
        st_idle: begin
          cnt <= 3'h0;
          if (!link.dat) begin
            state <= st_ins;
          end
        end
        st_ins: begin
          ins <= next_ins;
          cnt <= cnt + 3'h1;
          if (cnt == 3'h1) begin
            cnt <= 3'h0;
            if (next_ins == `TDFA_INS_DATA_WR || next_ins == `TDFA_INS_ADDR_WR) begin
              state <= st_wdat;
            end else begin
              state <= st_turn;
            end
          end
        end
        st_wdat: begin
          shift <= wbyte;
          cnt <= cnt + 3'h1;
          if (cnt == 3'h7) begin
            state <= st_idle;
          end
        end
        st_turn: begin
          shift <= rd_val;
          cnt <= 3'h0;
          state <= st_rdat;
        end
        st_rdat: begin
          shift <= {shift[6:0], 1'b0};
          cnt <= cnt + 3'h1;
          if (cnt == 3'h7) begin
            state <= st_idle;
          end
        end
      endcase
    end
  end

  // pin driven only inside the read phase of a frame
  always_ff @(posedge link.link_clk) begin
    if (lrst) begin
      link.dev_oe_n <= 1'b1;
      link.dev_o <= 1'b1;
    end else if (state == st_turn) begin
      link.dev_oe_n <= 1'b0;
      link.dev_o <= rd_val[7];
    end else if (state == st_rdat && cnt != 3'h7) begin
      link.dev_o <= shift[6];
    end else begin
      link.dev_oe_n <= 1'b1;
      link.dev_o <= 1'b1;
    end
  end

  // any frame halts the core; only a system reset resumes it
  always_ff @(posedge link.link_clk) begin
    if (lrst) begin
      halt_l <= 1'b0;
    end else if (state == st_idle && !link.dat) begin
      halt_l <= 1'b1;
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (lrst) begin
      sel <= `TDFA_SELECT_RESET;
    end else if (wdone && ins == `TDFA_INS_ADDR_WR) begin
      sel <= wbyte;
    end
  end

  // a wrong code restarts the sequence; once open only reset closes it
  always_ff @(posedge link.link_clk) begin
    if (lrst) begin
      ctl <= `TDFA_CTL_RESET;
      lock <= lk_locked;
    end else if (wdone && ins == `TDFA_INS_DATA_WR && sel == `TDFA_ADDR_CTL) begin
      ctl <= wbyte;
      if (lock != lk_open) begin
        if (wbyte == `TDFA_UNLOCK_FIRST) begin
          lock <= lk_first;
        end else if (lock == lk_first && wbyte == `TDFA_UNLOCK_SECOND) begin
          lock <= lk_open;
        end else begin
          lock <= lk_locked;
        end
      end
    end
  end

  always_ff @(posedge link.link_clk) begin
    rd_sync <= {rd_sync[1:0], rd_tgl};
    done_sync <= {done_sync[1:0], done_tgl};
  end

  // writes before unlock are dropped; the first byte of a sequence that is a command code is its command
  always_ff @(posedge link.link_clk) begin
    if (lrst) begin
      program_data_port <= `TDFA_DATA_RESET;
      cmd_phase <= 1'b0;
      byte_hold <= 8'h00;
      cmd_hold <= 1'b0;
      byte_tgl <= 1'b0;
    end else begin
      if (lock != lk_open) begin
        cmd_phase <= 1'b1;
      end else if (done_sync[2] != done_sync[1]) begin
        cmd_phase <= 1'b1;
      end else if (wdone && ins == `TDFA_INS_DATA_WR && sel == `TDFA_ADDR_DATA) begin
        cmd_phase <= cmd_phase && (cmd_of(wbyte) == tdfa_cmd_none);
      end
      if (lock == lk_open && wdone && ins == `TDFA_INS_DATA_WR && sel == `TDFA_ADDR_DATA) begin
        program_data_port <= wbyte;
        byte_hold <= wbyte;
        cmd_hold <= cmd_phase && (cmd_of(wbyte) != tdfa_cmd_none);
        byte_tgl <= ~byte_tgl;
      end else if (rd_sync[2] != rd_sync[1]) begin
        program_data_port <= rdata_hold;
      end
    end
  end

  // system domain: level crossings and byte delivery
  always_ff @(posedge clk) begin
    halt_m <= halt_l;
    open_m <= (lock == lk_open);
    pin_m <= link.dat;
    pin_s <= pin_m;
    byte_sync <= {byte_sync[1:0], byte_tgl};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      core_halted <= 1'b0;
      prog_enabled <= 1'b0;
    end else begin
      core_halted <= halt_m;
      prog_enabled <= open_m;
    end
  end

  // the pin is lent to the user only outside a session; frozen value while halted
  always_ff @(posedge clk) begin
    if (rst) begin
      user_pin_in <= 1'b1;
    end else if (!core_halted) begin
      user_pin_in <= pin_s;
    end
  end

  // byte hold is stable for a whole frame after the toggle, so it is safe to sample here
  always_ff @(posedge clk) begin
    if (rst) begin
      flash_byte_stb <= 1'b0;
      flash_byte <= 8'h00;
      flash_byte_is_cmd <= 1'b0;
      flash_cmd <= tdfa_cmd_none;
    end else begin
      flash_byte_stb <= byte_sync[2] != byte_sync[1];
      if (byte_sync[2] != byte_sync[1]) begin
        flash_byte <= byte_hold;
        flash_byte_is_cmd <= cmd_hold;
        if (cmd_hold) begin
          flash_cmd <= cmd_of(byte_hold);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_hold <= 8'h00;
      rd_tgl <= 1'b0;
      done_tgl <= 1'b0;
    end else begin
      if (flash_rdata_stb) begin
        rdata_hold <= flash_rdata;
        rd_tgl <= ~rd_tgl;
      end
      if (flash_done) begin
        done_tgl <= ~done_tgl;
      end
    end
  end

endmodule // tdfa_target

`default_nettype wire

// ==== core/tdfa_map.svh ====
// register offsets, codes and timing counts of the two-wire debug flash access port
// included by both link ends; definitions only
`ifndef TDFA_MAP_SVH
`define TDFA_MAP_SVH

// data registers on the far side of the debug register select
`define TDFA_ADDR_PART 8'h00
`define TDFA_ADDR_REV 8'h01
`define TDFA_ADDR_CTL 8'h02
`define TDFA_ADDR_DATA 8'hb4
`define TDFA_SELECT_RESET 8'h00
`define TDFA_CTL_RESET 8'h00
`define TDFA_DATA_RESET 8'h00

// unlock codes for the program enable control register
`define TDFA_UNLOCK_FIRST 8'h02
`define TDFA_UNLOCK_SECOND 8'h01

// flash command codes carried by the program data port
`define TDFA_CMD_BLOCK_READ 8'h06
`define TDFA_CMD_BLOCK_WRITE 8'h07
`define TDFA_CMD_PAGE_ERASE 8'h08
`define TDFA_CMD_DEVICE_ERASE 8'h03

// frame instruction codes, sent msb first after the start bit
`define TDFA_INS_DATA_RD 2'h0
`define TDFA_INS_DATA_WR 2'h1
`define TDFA_INS_ADDR_WR 2'h2
`define TDFA_INS_ADDR_RD 2'h3

// host command port register offsets
`define TDFA_HREG_CTRL 3'h0
`define TDFA_HREG_TXDATA 3'h1
`define TDFA_HREG_STATUS 3'h2
`define TDFA_HREG_RXDATA 3'h3
`define TDFA_HREG_TRST 3'h4

// host status bit positions
`define TDFA_STAT_BUSY 0
`define TDFA_STAT_RXVALID 1

// system clocks per half period of the link clock made by the host
`define TDFA_LINK_HALF 4

`endif

// ==== core/tdfa_pkg.sv ====
// types shared by both ends of the two-wire debug flash access port
// no assumptions beyond a SystemVerilog compiler
package tdfa_pkg;

  typedef enum logic [2:0] {
    tdfa_cmd_none,
    tdfa_cmd_block_read,
    tdfa_cmd_block_write,
    tdfa_cmd_page_erase,
    tdfa_cmd_device_erase
  } tdfa_cmd_e;

endpackage

// ==== core/tdfa_if.sv ====
// link between the debug host and the target: clock pin and shared data pin
// the data pin is pulled high; either end pulls it low by enabling a low drive
`timescale 1ns/100ps
`default_nettype none

interface tdfa_if;
  logic link_clk;
  logic host_o;
  logic host_oe_n;
  logic dev_o;
  logic dev_oe_n;
  logic dat;

  // wired level with pull-up
  assign dat = ~((~host_oe_n & ~host_o) | (~dev_oe_n & ~dev_o));

  modport host (output link_clk, output host_o, output host_oe_n, input dat);
  modport target (input link_clk, output dev_o, output dev_oe_n, input dat);
endinterface

`default_nettype wire

// ==== core/tdfa_host.sv ====
// host end of the two-wire debug port: makes the link clock and runs one frame per order
// assumes the target samples on the rising link edge and drives reads after it
`timescale 1ns/100ps
`include "tdfa_map.svh"
`default_nettype none

module tdfa_host
  import tdfa_pkg::*;
#(
  parameter int HALF = `TDFA_LINK_HALF // at least 2, so reads pass the synchroniser
) (
  input wire logic clk,
  input wire logic rst,
  tdfa_if.host link,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic target_rst
);

  typedef enum logic [2:0] {h_idle, h_start, h_ins, h_wdat, h_turn, h_rdat} tdfa_host_state_e;

  tdfa_host_state_e state;
  logic [15:0] dcnt;
  logic tick_rise, tick_fall;
  logic dat_m, dat_s;
  logic pend;
  logic busy;
  logic [1:0] ins;
  logic [7:0] tx;
  logic [7:0] sh;
  logic [7:0] rx;
  logic rx_valid;
  logic [2:0] cnt;
  logic rx_done;

  assign tick_rise = (dcnt == 16'(HALF - 1)) && !link.link_clk;
  assign tick_fall = (dcnt == 16'(HALF - 1)) && link.link_clk;
  assign busy = pend || (state != h_idle);
  assign rx_done = tick_rise && state == h_rdat && cnt == 3'h7;

  // free-running so the target's reset synchroniser always has edges
  always_ff @(posedge clk) begin
    if (rst) begin
      dcnt <= 16'h0000;
      link.link_clk <= 1'b0;
    end else if (dcnt == 16'(HALF - 1)) begin
      dcnt <= 16'h0000;
      link.link_clk <= ~link.link_clk;
    end else begin
      dcnt <= dcnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    dat_m <= link.dat;
    dat_s <= dat_m;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend <= 1'b0;
      ins <= `TDFA_INS_DATA_RD;
      tx <= 8'h00;
      target_rst <= 1'b0;
    end else begin
      if (wr && addr == `TDFA_HREG_CTRL && !busy) begin
        ins <= wdata[1:0];
        pend <= 1'b1;
      end else if (tick_fall && state == h_idle) begin
        pend <= 1'b0;
      end
      if (wr && addr == `TDFA_HREG_TXDATA) begin
        tx <= wdata;
      end
      if (wr && addr == `TDFA_HREG_TRST) begin
        target_rst <= wdata[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= h_idle;
      cnt <= 3'h0;
      sh <= 8'h00;
      link.host_o <= 1'b1;
      link.host_oe_n <= 1'b1;
    end else if (tick_fall) begin
      unique case (state)
        h_idle: begin
          if (pend) begin
            link.host_oe_n <= 1'b0;
            link.host_o <= 1'b0;
            state <= h_start;
          end
        end
        h_start: begin
          link.host_o <= ins[1];
          cnt <= 3'h0;
          state <= h_ins;
        end
        h_ins: begin
          if (cnt == 3'h0) begin
            link.host_o <= ins[0];
            cnt <= 3'h1;
          end else if (ins == `TDFA_INS_DATA_WR || ins == `TDFA_INS_ADDR_WR) begin
            link.host_o <= tx[7];
            sh <= {tx[6:0], 1'b0};
            cnt <= 3'h0;
            state <= h_wdat;
          end else begin
            link.host_oe_n <= 1'b1; // turnaround: hand the pin over
            link.host_o <= 1'b1;
            state <= h_turn;
          end
        end
        h_wdat: begin
          cnt <= cnt + 3'h1;
          if (cnt == 3'h7) begin
            link.host_oe_n <= 1'b1;
            link.host_o <= 1'b1;
            state <= h_idle;
          end else begin
            link.host_o <= sh[7];
            sh <= {sh[6:0], 1'b0};
          end
        end
        h_turn: begin
          cnt <= 3'h0;
          state <= h_rdat;
        end
        h_rdat: begin
        end
      endcase
    end else if (tick_rise && state == h_rdat) begin
      sh <= {sh[6:0], dat_s};
      cnt <= cnt + 3'h1;
      if (cnt == 3'h7) begin
        state <= h_idle;
      end
    end
  end

  // a read of the data register that meets a new result leaves valid set
  always_ff @(posedge clk) begin
    if (rst) begin
      rx <= 8'h00;
      rx_valid <= 1'b0;
    end else if (rx_done) begin
      rx <= {sh[6:0], dat_s};
      rx_valid <= 1'b1;
    end else if (rd && addr == `TDFA_HREG_RXDATA) begin
      rx_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        `TDFA_HREG_CTRL: rdata <= {6'h00, ins};
        `TDFA_HREG_TXDATA: rdata <= tx;
        `TDFA_HREG_STATUS: rdata <= {6'h00, rx_valid, busy};
        `TDFA_HREG_RXDATA: rdata <= rx;
        `TDFA_HREG_TRST: rdata <= {7'h00, target_rst};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // tdfa_host

`default_nettype wire

// ==== testbench/tdfa_chk_sva.sv ====
// checker for the two-wire debug link and the target's halt, unlock and flash strobe outputs
// assumes both ends share one system clock and rst is the target's system reset
`timescale 1ns/100ps
`default_nettype none

module tdfa_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_oe_n,
  input wire logic dev_oe_n,
  input wire logic core_halted,
  input wire logic prog_enabled,
  input wire logic user_pin_in,
  input wire logic flash_byte_stb
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  stb_needs_unlock_a: assert property (flash_byte_stb |-> prog_enabled)
    else $error("flash byte strobe while programming locked");
  unlock_sticks_a: assert property (prog_enabled |=> prog_enabled)
    else $error("programming enable dropped without reset");
  halt_sticks_a: assert property (core_halted |=> core_halted)
    else $error("halt released while debug session open");
  unlock_when_halted_a: assert property ($rose(prog_enabled) |-> core_halted)
    else $error("programming enabled on a running core");
  halt_from_frame_a: assert property ($rose(core_halted) |-> !host_oe_n)
    else $error("halt raised with no frame on the pin");
  // the user input is frozen once halted; the start bit of the first frame still reaches it before the halt
  user_pin_frozen_a: assert property (core_halted && $past(core_halted) |-> $stable(user_pin_in))
    else $error("user pin input moved while halted");
  pin_free_running_a: assert property (!core_halted |-> dev_oe_n)
    else $error("target drives data pin while not halted");
  no_contention_a: assert property (!dev_oe_n |-> host_oe_n)
    else $error("host and target drive the data pin together");
  stb_single_a: assert property (flash_byte_stb |=> !flash_byte_stb)
    else $error("flash byte strobe longer than one cycle");

  unlock_c: cover property ($rose(prog_enabled));
  flash_byte_c: cover property (flash_byte_stb);
  target_read_c: cover property ($fell(dev_oe_n));
endmodule // tdfa_chk

`default_nettype wire

// ==== testbench/tb_two_wire_debug_flash_access.sv ====
// bench joining host and target ends over the link, driving the host command port
// assumes the host makes the link clock from clk and the target runs on the same clk
`timescale 1ns/100ps
`include "tdfa_map.svh"
`default_nettype none

module tb_two_wire_debug_flash_access
  import tdfa_pkg::*;
;
  logic clk = 1'b0;
  logic rst, tgt_hold, wr, rd, flash_rdata_stb, flash_done;
  logic [2:0] addr;
  logic [7:0] wdata, flash_rdata, r, d, last_byte;
  wire logic [7:0] rdata, flash_byte;
  wire logic target_rst, tgt_rst, core_halted, prog_enabled, user_pin_in;
  wire logic flash_byte_is_cmd, flash_byte_stb;
  wire tdfa_cmd_e flash_cmd;
  tdfa_cmd_e last_cmd;
  logic last_flag;
  logic [31:0] seed = 32'h00017d02;
  int fails = 0;
  int checks_done = 0;
  int stb_cnt = 0;
  int n0;
  logic [7:0] cmds [4] = '{`TDFA_CMD_BLOCK_READ, `TDFA_CMD_BLOCK_WRITE,
    `TDFA_CMD_PAGE_ERASE, `TDFA_CMD_DEVICE_ERASE};
  localparam logic [7:0] PART = 8'h3c; // arbitrary value
  localparam logic [7:0] REV = 8'h05; // arbitrary value

  always #20 clk = ~clk;
  // the target reset is stretched so its link-side synchroniser sees it
  assign tgt_rst = tgt_hold | target_rst;

  tdfa_if lnk();
  tdfa_host i_tdfa_host (.clk(clk), .rst(rst), .link(lnk), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .target_rst(target_rst));
  tdfa_target #(.PART_ID(PART), .REV_ID(REV)) i_tdfa_target (.clk(clk), .rst(tgt_rst),
    .link(lnk), .core_halted(core_halted), .prog_enabled(prog_enabled),
    .user_pin_in(user_pin_in), .flash_byte(flash_byte), .flash_byte_is_cmd(flash_byte_is_cmd),
    .flash_cmd(flash_cmd), .flash_byte_stb(flash_byte_stb), .flash_rdata(flash_rdata),
    .flash_rdata_stb(flash_rdata_stb), .flash_done(flash_done));
  tdfa_chk i_tdfa_chk (.clk(clk), .rst(tgt_rst), .host_oe_n(lnk.host_oe_n),
    .dev_oe_n(lnk.dev_oe_n), .core_halted(core_halted), .prog_enabled(prog_enabled),
    .user_pin_in(user_pin_in), .flash_byte_stb(flash_byte_stb));

  always @(posedge clk) begin
    if (flash_byte_stb === 1'b1) begin
      stb_cnt <= stb_cnt + 1;
      last_byte <= flash_byte;
      last_flag <= flash_byte_is_cmd;
      last_cmd <= flash_cmd;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic tdfa_cmd_e cmd_of(input logic [7:0] c);
    case (c)
      `TDFA_CMD_BLOCK_READ: return tdfa_cmd_block_read;
      `TDFA_CMD_BLOCK_WRITE: return tdfa_cmd_block_write;
      `TDFA_CMD_PAGE_ERASE: return tdfa_cmd_page_erase;
      `TDFA_CMD_DEVICE_ERASE: return tdfa_cmd_device_erase;
      default: return tdfa_cmd_none;
    endcase
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic frame(input logic [1:0] ins, input logic [7:0] v, output logic [7:0] res);
    logic [7:0] st;
    int n;
    wr_reg(`TDFA_HREG_TXDATA, v);
    wr_reg(`TDFA_HREG_CTRL, {6'h00, ins});
    st = 8'h01;
    n = 0;
    while (st[`TDFA_STAT_BUSY] !== 1'b0 && n < 400) begin
      rd_reg(`TDFA_HREG_STATUS, st);
      n++;
    end
    check("frame busy", {7'h00, st[`TDFA_STAT_BUSY]}, 8'h00);
    rd_reg(`TDFA_HREG_RXDATA, res);
    // user-side strobes land a few cycles after the last bit
    repeat (8) @(posedge clk);
  endtask

  task automatic sel(input logic [7:0] a);
    frame(`TDFA_INS_ADDR_WR, a, r);
  endtask

  task automatic dwr(input logic [7:0] v);
    frame(`TDFA_INS_DATA_WR, v, r);
  endtask

  task automatic pulse_done();
    @(posedge clk);
    flash_done <= 1'b1;
    @(posedge clk);
    flash_done <= 1'b0;
  endtask

  task automatic finish_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(40 * 30000);
    fails++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    tgt_hold = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    flash_rdata = 8'h00;
    flash_rdata_stb = 1'b0;
    flash_done = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (30) @(posedge clk);
    tgt_hold <= 1'b0;
    repeat (40) @(posedge clk);
    check("halt idle", {7'h00, core_halted}, 8'h00);
    check("user pin idle", {7'h00, user_pin_in}, 8'h01);
    sel(`TDFA_ADDR_PART);
    frame(`TDFA_INS_DATA_RD, 8'h00, d);
    check("part id", d, PART);
    seed = lfsr(seed);
    dwr(seed[7:0]);
    frame(`TDFA_INS_DATA_RD, 8'h00, d);
    check("part id kept", d, PART);
    sel(`TDFA_ADDR_REV);
    frame(`TDFA_INS_DATA_RD, 8'h00, d);
    check("revision", d, REV);
    check("halted", {7'h00, core_halted}, 8'h01);
    sel(`TDFA_ADDR_CTL);
    dwr(`TDFA_UNLOCK_SECOND);
    dwr(`TDFA_UNLOCK_FIRST);
    dwr(8'h55);
    dwr(`TDFA_UNLOCK_SECOND);
    check("wrong order locked", {7'h00, prog_enabled}, 8'h00);
    frame(`TDFA_INS_DATA_RD, 8'h00, d);
    check("control readback", d, `TDFA_UNLOCK_SECOND);
    sel(`TDFA_ADDR_DATA);
    n0 = stb_cnt;
    dwr(`TDFA_CMD_BLOCK_WRITE);
    check("locked data port", 8'(stb_cnt - n0), 8'h00);
    sel(`TDFA_ADDR_CTL);
    dwr(`TDFA_UNLOCK_FIRST);
    dwr(`TDFA_UNLOCK_SECOND);
    check("unlocked", {7'h00, prog_enabled}, 8'h01);
    sel(`TDFA_ADDR_DATA);
    for (int i = 0; i < 4; i++) begin
      n0 = stb_cnt;
      dwr(cmds[i]);
      check("cmd strobe", 8'(stb_cnt - n0), 8'h01);
      check("cmd flag", {7'h00, last_flag}, 8'h01);
      check("cmd code", {5'h00, last_cmd}, {5'h00, cmd_of(cmds[i])});
      seed = lfsr(seed);
      dwr(seed[7:0]);
      check("data byte", last_byte, seed[7:0]);
      check("data flag", {7'h00, last_flag}, 8'h00);
      pulse_done();
    end
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      @(posedge clk);
      flash_rdata <= seed[15:8];
      flash_rdata_stb <= 1'b1;
      @(posedge clk);
      flash_rdata_stb <= 1'b0;
      frame(`TDFA_INS_DATA_RD, 8'h00, d);
      check("flash read byte", d, seed[15:8]);
    end
    sel(`TDFA_ADDR_CTL);
    dwr(8'h00);
    check("enable sticks", {7'h00, prog_enabled}, 8'h01);
    wr_reg(`TDFA_HREG_TRST, 8'h01);
    repeat (30) @(posedge clk);
    wr_reg(`TDFA_HREG_TRST, 8'h00);
    repeat (40) @(posedge clk);
    check("reset relocks", {7'h00, prog_enabled}, 8'h00);
    check("reset resumes", {7'h00, core_halted}, 8'h00);
    sel(`TDFA_ADDR_CTL);
    frame(`TDFA_INS_DATA_RD, 8'h00, d);
    check("control reset", d, `TDFA_CTL_RESET);
    frame(`TDFA_INS_ADDR_RD, 8'h00, d);
    check("select readback", d, `TDFA_ADDR_CTL);
    finish_test();
  end
endmodule // tb_two_wire_debug_flash_access

`default_nettype wire
